//--- irq_power_cfg.svh
// constants for the interrupt vectoring and power mode control block
// assumes a wishbone byte address of eight bits and 32-bit data words
//
// Functional notes
// - accepted interrupt wakes; return restores prior mode
// - level 0: core halted, all clocks, loop on
// - level 1: core halted, loop control stopped
// - level 2: only auxiliary clock; sub clock off
// - level 3: level 2 plus oscillator dc off
// - level 4: crystal stopped, everything off
// - state word layout, all bits reset zero
// - halt bit stops core execution
// - loop disable bit stops frequency lock loop
// - clock gate bit stops main, sub clocks
// - crystal stop bit disables crystal oscillator
// - loop disable and gate: dc generator off
// - power bits stacked on accept, restored on return
// - vectors occupy words 0FFE0h to 0FFFFh
// - reset causes fetch 0FFFEh, priority 15
// - nmi, osc fault, access fault share 0FFFCh
// - nmi class: own enable only, global ignored
// - capture 1,2, wrap at 0FFEAh; capture 0 0FFECh
// - port 1 flags share 0FFE8h, priority 4
// - port 2 flags share 0FFE2h, priority 1
// - request flags live in peripherals, not here
// - nmi class and watchdog enables at 0h
`ifndef IRQ_POWER_CFG_SVH
`define IRQ_POWER_CFG_SVH

// register byte offsets
`define OFS_IRQ_EN1 8'h00
`define OFS_IRQ_EN2 8'h04
`define OFS_SRC_EN 8'h08
`define OFS_PORT_EN 8'h0C
`define OFS_STATE_WORD 8'h10
`define OFS_STATUS 8'h14

// state word fields
`define SW_OVERFLOW 8
`define SW_CLK_GATE 7
`define SW_LOOP_OFF 6
`define SW_XTAL_STOP 5
`define SW_CORE_HALT 4
`define SW_GIE 3
`define SW_USED_MASK 16'h01FF
`define SW_RESET 16'h0000

// enable register 1 fields
`define EN1_WDOG 0
`define EN1_OSC_FAULT 1
`define EN1_PIN_NMI 4
`define EN1_ACC_VIOL 5
// enable register 2 field
`define EN2_TICK 7
// source enable register fields
`define SEN_CMP 0
`define SEN_CC0 1
`define SEN_CC1 2
`define SEN_CC2 3
`define SEN_WRAP 4
`define EN_RESET 8'h00

// vector base and priorities
`define VEC_BASE 16'hFFE0
`define PRI_RESET 4'hF
`define PRI_NMI 4'hE
`define PRI_CMP 4'hB
`define PRI_WDOG 4'hA
`define PRI_CC0 4'h6
`define PRI_CC12 4'h5
`define PRI_PORT1 4'h4
`define PRI_PORT2 4'h1
`define PRI_TICK 4'h0

`endif

//--- irq_power_pkg.sv
// types shared by the interrupt vectoring and power mode control block
// assumes nothing of its surroundings
package irq_power_pkg;
  // operating state decoded from the power bits
  typedef enum logic [2:0] {
    ACTIVE_STATE = 3'h0,
    SLEEP_LEVEL_0 = 3'h1,
    SLEEP_LEVEL_1 = 3'h2,
    SLEEP_LEVEL_2 = 3'h3,
    SLEEP_LEVEL_3 = 3'h4,
    SLEEP_LEVEL_4 = 3'h5
  } sleep_level_t;
  // acceptance sequencer; one bit flips per step except done back to idle
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_REQ = 2'b01,
    ACC_DONE = 2'b11
  } accept_state_t;
endpackage

//--- irq_power_ctrl.sv
// interrupt vectoring and power mode control with a wishbone slave
// assumes the core acknowledges requests even while halted and does
// the actual stack writes; peripherals hold and clear their own flags
`timescale 1ns/10ps
`include "irq_power_cfg.svh"

module irq_power_ctrl import irq_power_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // reset class events, one-cycle pulses
  input wire logic ext_reset_i,
  input wire logic wdt_reset_i,
  input wire logic flash_key_fault_i,
  // peripheral flag levels
  input wire logic pin_nmi_flag_i,
  input wire logic osc_fault_flag_i,
  input wire logic flash_access_viol_flag_i,
  input wire logic comparator_flag_i,
  input wire logic watchdog_flag_i,
  input wire logic capture0_flag_i,
  input wire logic capture1_flag_i,
  input wire logic capture2_flag_i,
  input wire logic timer_wrap_flag_i,
  input wire logic [7:0] port1_pin_flags_i,
  input wire logic [7:0] port2_pin_flags_i,
  input wire logic basic_tick_flag_i,
  // core side
  output logic irq_req_o,
  output logic [15:0] irq_vector_o,
  output logic [3:0] irq_prio_o,
  input wire logic irq_ack_i,
  output logic [15:0] irq_taken_o,
  output logic stack_push_o,
  output logic [15:0] stack_word_o,
  input wire logic return_from_irq_i,
  input wire logic [15:0] return_word_i,
  // power controls
  output logic core_halt_o,
  output logic freq_loop_off_o,
  output logic main_clk_stop_o,
  output logic sub_clk_stop_o,
  output logic crystal_stop_o,
  output logic dco_dc_off_o,
  output sleep_level_t sleep_level_o
);

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic [15:0] state_word_reg; // processor_state_word
  logic [15:0] state_word_next;
  logic [7:0] irq_en1_reg; // nmi class and watchdog enables
  logic [7:0] irq_en2_reg; // tick enable
  logic [7:0] src_en_reg; // comparator and timer enables
  logic [15:0] port_en_reg; // port 2 high byte, port 1 low byte
  logic reset_pend_reg; // reset vector still owed
  accept_state_t acc_reg; // acceptance sequencer
  logic [3:0] win_prio_reg; // latched winning slot
  logic [15:0] req_vec; // one bit per priority slot
  logic [3:0] win_prio; // highest requesting slot
  logic win_any;
  logic take; // core takes the request now
  logic wb_hit; // new bus cycle this edge
  logic wr_en; // write lands on the edge where the master sees ack
  logic [31:0] rd_data;
  logic global_irq_enable;

  assign global_irq_enable = state_word_reg[`SW_GIE];
  assign take = (acc_reg == ACC_REQ) && irq_ack_i;
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  //////////////////////////////////////////////////////////////////////////
  // request gathering

  // flags are only sampled, never held here
  always_comb begin
    req_vec = 16'h0000;
    // reset class needs no enable at all
    req_vec[`PRI_RESET] = reset_pend_reg;
    // nmi class: individual enables only, no global gate
    req_vec[`PRI_NMI] = (pin_nmi_flag_i && irq_en1_reg[`EN1_PIN_NMI]) ||
                        (osc_fault_flag_i && irq_en1_reg[`EN1_OSC_FAULT]) ||
                        (flash_access_viol_flag_i && irq_en1_reg[`EN1_ACC_VIOL]);
    // maskable ones need both enables
    if (global_irq_enable) begin
      req_vec[`PRI_CMP] = comparator_flag_i && src_en_reg[`SEN_CMP];
      req_vec[`PRI_WDOG] = watchdog_flag_i && irq_en1_reg[`EN1_WDOG];
      req_vec[`PRI_CC0] = capture0_flag_i && src_en_reg[`SEN_CC0];
      req_vec[`PRI_CC12] = (capture1_flag_i && src_en_reg[`SEN_CC1]) ||
                           (capture2_flag_i && src_en_reg[`SEN_CC2]) ||
                           (timer_wrap_flag_i && src_en_reg[`SEN_WRAP]);
      req_vec[`PRI_PORT1] = |(port1_pin_flags_i & port_en_reg[7:0]);
      req_vec[`PRI_PORT2] = |(port2_pin_flags_i & port_en_reg[15:8]);
      req_vec[`PRI_TICK] = basic_tick_flag_i && irq_en2_reg[`EN2_TICK];
    end
  end

  // priority encoder: later (higher) slots overwrite earlier ones
  always_comb begin
    win_prio = 4'h0;
    win_any = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (req_vec[i]) begin
        win_prio = 4'(i);
        win_any = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // acceptance sequencer

  // idle picks a winner, req waits on the core, done pushes the word
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      acc_reg <= ACC_IDLE;
    end else begin
      case (acc_reg)
        ACC_IDLE: begin
          if (win_any) begin
            acc_reg <= ACC_REQ;
          end
        end
        ACC_REQ: begin
          if (irq_ack_i) begin
            acc_reg <= ACC_DONE;
          end
        end
        // one idle slot lets the cleared global enable take hold
        default: begin
          acc_reg <= ACC_IDLE;
        end
      endcase
    end
  end

  // winner is frozen while the core decides, so the vector cannot slip
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      win_prio_reg <= 4'h0;
    end else if (acc_reg == ACC_IDLE && win_any) begin
      win_prio_reg <= win_prio;
    end
  end

  // request, vector and priority to the core
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_req_o <= 1'b0;
      irq_vector_o <= `VEC_BASE;
      irq_prio_o <= 4'h0;
    end else begin
      irq_req_o <= (acc_reg == ACC_IDLE && win_any) || (acc_reg == ACC_REQ && !irq_ack_i);
      if (acc_reg == ACC_IDLE && win_any) begin
        irq_prio_o <= win_prio;
        irq_vector_o <= `VEC_BASE + {11'h000, win_prio, 1'b0};
      end
    end
  end

  // taken pulse tells the source slot; push carries the old state word
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_taken_o <= 16'h0000;
      stack_push_o <= 1'b0;
      stack_word_o <= `SW_RESET;
    end else begin
      irq_taken_o <= take ? (16'h0001 << win_prio_reg) : 16'h0000;
      // a reset vector starts afresh and stacks nothing
      stack_push_o <= take && (win_prio_reg != `PRI_RESET);
      if (take) begin
        stack_word_o <= state_word_reg;
      end
    end
  end

  // reset vector owed after power-up and each reset class event
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reset_pend_reg <= 1'b1;
    end else if (ext_reset_i || wdt_reset_i || flash_key_fault_i) begin
      reset_pend_reg <= 1'b1;
    end else if (take && win_prio_reg == `PRI_RESET) begin
      reset_pend_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state word

  // return beats accept, accept beats a bus write
  always_comb begin
    state_word_next = state_word_reg;
    if (return_from_irq_i) begin
      // the handler may have edited the stacked copy
      state_word_next = return_word_i & `SW_USED_MASK;
    end else if (take && win_prio_reg == `PRI_RESET) begin
      state_word_next = `SW_RESET;
    end else if (take) begin
      // wake: all power bits and the global enable clear
      state_word_next[`SW_CLK_GATE] = 1'b0;
      state_word_next[`SW_LOOP_OFF] = 1'b0;
      state_word_next[`SW_XTAL_STOP] = 1'b0;
      state_word_next[`SW_CORE_HALT] = 1'b0;
      state_word_next[`SW_GIE] = 1'b0;
    end else if (wr_en && wb_adr_i == `OFS_STATE_WORD) begin
      if (wb_sel_i[0]) begin
        state_word_next[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        state_word_next[8] = wb_dat_i[8]; // reserved bits stay zero
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_word_reg <= `SW_RESET;
    end else begin
      state_word_reg <= state_word_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power controls, registered from the next state word

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      core_halt_o <= 1'b0;
      freq_loop_off_o <= 1'b0;
      main_clk_stop_o <= 1'b0;
      sub_clk_stop_o <= 1'b0;
      crystal_stop_o <= 1'b0;
      dco_dc_off_o <= 1'b0;
    end else begin
      core_halt_o <= state_word_next[`SW_CORE_HALT];
      freq_loop_off_o <= state_word_next[`SW_LOOP_OFF];
      main_clk_stop_o <= state_word_next[`SW_CLK_GATE];
      sub_clk_stop_o <= state_word_next[`SW_CLK_GATE];
      crystal_stop_o <= state_word_next[`SW_XTAL_STOP];
      dco_dc_off_o <= state_word_next[`SW_LOOP_OFF] &&
                      state_word_next[`SW_CLK_GATE];
    end
  end

  // sleep level decode; odd mixes map to the nearest named level
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sleep_level_o <= ACTIVE_STATE;
    end else if (!state_word_next[`SW_CORE_HALT]) begin
      sleep_level_o <= ACTIVE_STATE;
    end else if (state_word_next[`SW_XTAL_STOP]) begin
      sleep_level_o <= SLEEP_LEVEL_4;
    end else if (state_word_next[`SW_CLK_GATE] && state_word_next[`SW_LOOP_OFF]) begin
      sleep_level_o <= SLEEP_LEVEL_3;
    end else if (state_word_next[`SW_CLK_GATE]) begin
      sleep_level_o <= SLEEP_LEVEL_2;
    end else if (state_word_next[`SW_LOOP_OFF]) begin
      sleep_level_o <= SLEEP_LEVEL_1;
    end else begin
      sleep_level_o <= SLEEP_LEVEL_0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // enable registers

  // nmi class enables self-clear on accept so a stuck source cannot loop
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_en1_reg <= `EN_RESET;
    end else if (wr_en && wb_adr_i == `OFS_IRQ_EN1 && wb_sel_i[0]) begin
      irq_en1_reg <= wb_dat_i[7:0] & 8'h33;
    end else if (take && win_prio_reg == `PRI_NMI) begin
      irq_en1_reg[`EN1_PIN_NMI] <= 1'b0;
      irq_en1_reg[`EN1_OSC_FAULT] <= 1'b0;
      irq_en1_reg[`EN1_ACC_VIOL] <= 1'b0;
    end
  end

  // plain enables for the remaining maskable sources
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_en2_reg <= `EN_RESET;
      src_en_reg <= `EN_RESET;
      port_en_reg <= {`EN_RESET, `EN_RESET};
    end else if (wr_en) begin
      if (wb_adr_i == `OFS_IRQ_EN2 && wb_sel_i[0]) begin
        irq_en2_reg <= wb_dat_i[7:0] & 8'h80;
      end else if (wb_adr_i == `OFS_SRC_EN && wb_sel_i[0]) begin
        src_en_reg <= wb_dat_i[7:0] & 8'h1F;
      end else if (wb_adr_i == `OFS_PORT_EN) begin
        if (wb_sel_i[0]) begin
          port_en_reg[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          port_en_reg[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wishbone read path and acknowledge

  // unmapped addresses read zero and ignore writes
  always_comb begin
    if (wb_adr_i == `OFS_IRQ_EN1) begin
      rd_data = {24'h00_0000, irq_en1_reg};
    end else if (wb_adr_i == `OFS_IRQ_EN2) begin
      rd_data = {24'h00_0000, irq_en2_reg};
    end else if (wb_adr_i == `OFS_SRC_EN) begin
      rd_data = {24'h00_0000, src_en_reg};
    end else if (wb_adr_i == `OFS_PORT_EN) begin
      rd_data = {16'h0000, port_en_reg};
    end else if (wb_adr_i == `OFS_STATE_WORD) begin
      rd_data = {16'h0000, state_word_reg};
    end else if (wb_adr_i == `OFS_STATUS) begin
      // live pending slots, sequencer busy, reset owed, sleep level
      rd_data = {req_vec, 8'h00, reset_pend_reg, irq_req_o, win_prio_reg, 2'b00} |
                {29'h0000_0000, sleep_level_o};
    end else begin
      rd_data = 32'h0000_0000;
    end
  end

  // one wait state; ack drops the cycle after it was given
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions

  chk_wake_on_accept: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    take |=> (state_word_reg[7:4] == 4'h0) ##1 !core_halt_o)
    else $error("power bits not cleared after accept");

  chk_return_restores: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    return_from_irq_i |=> state_word_reg == ($past(return_word_i) & 16'h01FF))
    else $error("state word not restored on return");

  chk_push_old_word: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (take && win_prio_reg != 4'hF) |=> stack_push_o && stack_word_o == $past(state_word_reg))
    else $error("stacked word wrong or push missing");

  chk_dco_both_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    dco_dc_off_o == (freq_loop_off_o && main_clk_stop_o))
    else $error("dc generator control mismatched");

  chk_global_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ($rose(irq_req_o) && irq_prio_o < 4'hE) |-> $past(global_irq_enable))
    else $error("maskable request raised without global enable");

  chk_vector_map: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    irq_req_o |-> irq_vector_o == 16'hFFE0 + {11'h000, irq_prio_o, 1'b0})
    else $error("vector address does not match priority");

  chk_reset_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ext_reset_i && acc_reg == ACC_IDLE && !win_any) |-> ##[1:3]
      (irq_req_o && irq_vector_o == 16'hFFFE))
    else $error("reset event did not raise the reset vector");

  chk_nmi_ignores_gie: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (acc_reg == ACC_IDLE && !global_irq_enable && pin_nmi_flag_i && irq_en1_reg[4] && !reset_pend_reg)
      |=> irq_req_o && irq_prio_o == 4'hE)
    else $error("nmi class blocked by global enable");

  chk_level4_crystal: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    sleep_level_o == SLEEP_LEVEL_4 |-> crystal_stop_o && core_halt_o)
    else $error("level 4 without crystal stop");

  chk_bus_ack_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held longer than one cycle");

  cov_maskable_taken: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    take && win_prio_reg == `PRI_PORT1);
  cov_nmi_taken: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    take && win_prio_reg == `PRI_NMI);
  cov_level3_wake: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    sleep_level_o == SLEEP_LEVEL_3 ##[1:20] take);
  cov_return: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    stack_push_o ##[1:50] return_from_irq_i);

endmodule

//--- core_model.sv
// core side partner: takes vectored requests after a settable delay
// assumes the bench drives returns and the peripheral flags itself
`timescale 1ns/10ps

module core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic irq_req_i,
  input wire logic [3:0] delay_i,
  output logic irq_ack_o
);
  logic [3:0] wait_reg; // cycles the request has stood so far

  //////////////////////////////////////////////////////////////////////
  // ack once the request has stood delay_i cycles; a halted core acks too
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_ack_o <= 1'b0;
      wait_reg <= 4'h0;
    end else if (irq_ack_o) begin
      // taken at this edge, so the request falls next cycle
      irq_ack_o <= 1'b0;
      wait_reg <= 4'h0;
    end else if (irq_req_i) begin
      irq_ack_o <= (wait_reg >= delay_i);
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

//--- interrupt_vector_and_power_mode_control_tb.sv
// self-checking bench for the vectoring and power mode block
// assumes the core model in its own file; flags are driven from here
`timescale 1ns/10ps
`include "irq_power_cfg.svh"

module interrupt_vector_and_power_mode_control_tb import irq_power_pkg::*; ;
  logic sys_clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ext_reset_i;
  logic wdt_reset_i, flash_key_fault_i, pin_nmi_flag_i, osc_fault_flag_i;
  logic flash_access_viol_flag_i, capture0_flag_i, capture1_flag_i, capture2_flag_i;
  logic timer_wrap_flag_i, irq_req_o, irq_ack_i, stack_push_o, return_from_irq_i;
  logic core_halt_o, freq_loop_off_o, main_clk_stop_o, sub_clk_stop_o;
  logic crystal_stop_o, dco_dc_off_o, comparator_flag_i, watchdog_flag_i, basic_tick_flag_i;
  logic [7:0] wb_adr_i, port1_pin_flags_i, port2_pin_flags_i;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic [15:0] irq_vector_o, irq_taken_o, stack_word_o, return_word_i;
  logic [3:0] irq_prio_o, dly;
  logic [2:0] b;
  sleep_level_t sleep_level_o;
  logic [31:0] seed = 32'h0000_004d; // xorshift state, starts at 77
  logic [15:0] mode_w [6] = '{16'h0000, 16'h0010, 16'h0050, 16'h0090, 16'h00d0, 16'h00f0};
  int fail_count = 0;
  int checked = 0;

  //////////////////////////////////////////////////////////////////////
  // every flag source is driven from the bench; the core model answers requests
  irq_power_ctrl i_dut (.sys_clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'b0011), .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_reset_i, .wdt_reset_i,
    .flash_key_fault_i, .pin_nmi_flag_i, .osc_fault_flag_i, .flash_access_viol_flag_i,
    .comparator_flag_i, .watchdog_flag_i, .capture0_flag_i, .capture1_flag_i,
    .capture2_flag_i, .timer_wrap_flag_i, .port1_pin_flags_i, .port2_pin_flags_i,
    .basic_tick_flag_i, .irq_req_o, .irq_vector_o, .irq_prio_o, .irq_ack_i,
    .irq_taken_o, .stack_push_o, .stack_word_o, .return_from_irq_i, .return_word_i,
    .core_halt_o, .freq_loop_off_o, .main_clk_stop_o, .sub_clk_stop_o, .crystal_stop_o,
    .dco_dc_off_o, .sleep_level_o);

  core_model i_core (.clk_i(sys_clk_i), .rst_n_i(rst_n_i), .irq_req_i(irq_req_o),
    .delay_i(dly), .irq_ack_o(irq_ack_i));

  //////////////////////////////////////////////////////////////////////
  // free running clock, 4 ns period
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected enable register, enable bit and priority of each flag source
  function automatic logic [7:0] en_adr(int k);
    return (k < 3 || k == 10) ? `OFS_IRQ_EN1 : (k < 7 || k == 9) ? `OFS_SRC_EN :
           (k == 11) ? `OFS_IRQ_EN2 : `OFS_PORT_EN;
  endfunction

  function automatic logic [31:0] en_val(int k, logic [2:0] bit_no);
    logic [31:0] t [3] = '{32'h0000_0010, 32'h0000_0002, 32'h0000_0020};
    if (k < 3) return t[k];
    if (k > 8) return (k == 11) ? 32'h0000_0080 : 32'h0000_0001;
    if (k < 7) return 32'h0000_0001 << (k - 2);
    return 32'h0000_0001 << (bit_no + ((k == 8) ? 8 : 0));
  endfunction

  function automatic logic [3:0] en_prio(int k);
    return (k < 3) ? 4'he : (k == 3) ? 4'h6 : (k < 7) ? 4'h5 : (k == 7) ? 4'h4 :
           (k == 8) ? 4'h1 : (k == 9) ? 4'hb : (k == 10) ? 4'ha : 4'h0;
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_up();
    fail_count++;
    $display("[ERR] %0t wait bound used up", $time);
    test_done();
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // one classic cycle; holds until ack is sampled high, then idles a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge sys_clk_i);
    while (wb_ack_o !== 1'b1) begin
      n++;
      if (n > 20) give_up();
      @(posedge sys_clk_i);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask

  // power outputs expected from a state word
  task automatic pw(input logic [15:0] w);
    chk(core_halt_o, w[4]);
    chk(freq_loop_off_o, w[6]);
    chk(main_clk_stop_o, w[7]);
    chk(sub_clk_stop_o, w[7]);
    chk(crystal_stop_o, w[5]);
    chk(dco_dc_off_o, w[6] & w[7]);
  endtask

  // peripheral side: a source raises or clears its own flag
  task automatic src(int k, logic v, logic [2:0] bit_no);
    case (k)
      0: pin_nmi_flag_i <= v;
      1: osc_fault_flag_i <= v;
      2: flash_access_viol_flag_i <= v;
      3: capture0_flag_i <= v;
      4: capture1_flag_i <= v;
      5: capture2_flag_i <= v;
      6: timer_wrap_flag_i <= v;
      7: port1_pin_flags_i <= v ? (8'h01 << bit_no) : 8'h00;
      8: port2_pin_flags_i <= v ? (8'h01 << bit_no) : 8'h00;
      9: comparator_flag_i <= v;
      10: watchdog_flag_i <= v;
      default: basic_tick_flag_i <= v;
    endcase
  endtask

  // waits for a request, checks its slot, then the accept pulses
  task automatic serve(input logic [3:0] p);
    int n = 0;
    while (irq_req_o !== 1'b1) begin
      n++;
      if (n > 40) give_up();
      @(posedge sys_clk_i);
    end
    chk(irq_vector_o, 16'hffe0 + {11'h000, p, 1'b0});
    chk(irq_prio_o, p);
    n = 0;
    while (irq_taken_o === 16'h0000) begin
      n++;
      if (n > 40) give_up();
      @(posedge sys_clk_i);
    end
    chk(irq_taken_o, 16'h0001 << p);
    chk(stack_push_o, p != 4'hf);
  endtask

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, ext_reset_i, wdt_reset_i} = '0;
    {flash_key_fault_i, pin_nmi_flag_i, osc_fault_flag_i, flash_access_viol_flag_i} = '0;
    {capture0_flag_i, capture1_flag_i, capture2_flag_i, timer_wrap_flag_i} = '0;
    {wb_adr_i, wb_dat_i, port1_pin_flags_i, port2_pin_flags_i, return_from_irq_i} = '0;
    {comparator_flag_i, watchdog_flag_i, basic_tick_flag_i} = '0;
    return_word_i = 16'hffff;
    dly = 4'h0;
    tick(2);
    rst_n_i <= 1'b1;
    serve(4'hf);
    rd(`OFS_STATE_WORD, 32'h0000_0000);
    rd(`OFS_IRQ_EN1, 32'h0000_0000);
    rd(8'h3c, 32'h0000_0000);
    // each documented mode by its bit pattern
    for (int i = 0; i < 6; i++) begin
      wr(`OFS_STATE_WORD, {16'h0000, mode_w[i]});
      tick(2);
      pw(mode_w[i]);
      chk(sleep_level_o, i);
    end
    // random words, enable kept clear; reserved bits must read zero
    repeat (8) begin
      r = xs() & 32'h0000_fff7;
      wr(`OFS_STATE_WORD, r);
      tick(2);
      rd(`OFS_STATE_WORD, r & 32'h0000_01ff);
      pw(r[15:0]);
    end
    // every source blocked first, then served; delay varies per source
    for (int k = 0; k < 12; k++) begin
      r = xs();
      b = r[2:0];
      dly <= r[6:3];
      wr(en_adr(k), (k < 3) ? 32'h0000_0000 : en_val(k, b));
      wr(`OFS_STATE_WORD, (k < 3) ? 32'h0000_0008 : 32'h0000_0000);
      src(k, 1'b1, b);
      tick(8);
      chk(irq_req_o, 1'b0);
      // nmi class is served with the global enable cleared
      if (k < 3) begin
        wr(`OFS_STATE_WORD, 32'h0000_0000);
      end
      wr((k < 3) ? en_adr(k) : `OFS_STATE_WORD, (k < 3) ? en_val(k, b) : 32'h0000_0008);
      serve(en_prio(k));
      src(k, 1'b0, b);
      tick(3);
    end
    // two pending sources: higher number first, the other after re-enable
    wr(`OFS_SRC_EN, 32'h0000_0002);
    wr(`OFS_PORT_EN, 32'h0000_0001);
    src(7, 1'b1, 3'h0);
    src(3, 1'b1, 3'h0);
    wr(`OFS_STATE_WORD, 32'h0000_0008);
    serve(4'h6);
    src(3, 1'b0, 3'h0);
    wr(`OFS_STATE_WORD, 32'h0000_0008);
    serve(4'h4);
    src(7, 1'b0, 3'h0);
    // wake from level 2, then return into a different mode
    wr(`OFS_PORT_EN, 32'h0000_0100);
    wr(`OFS_STATE_WORD, 32'h0000_0098);
    src(8, 1'b1, 3'h0);
    serve(4'h1);
    chk(stack_word_o, 16'h0098);
    src(8, 1'b0, 3'h0);
    tick(2);
    pw(16'h0000);
    return_word_i <= 16'hfe58;
    return_from_irq_i <= 1'b1;
    tick(1);
    return_from_irq_i <= 1'b0;
    return_word_i <= 16'h01a7;
    tick(2);
    chk(sleep_level_o, SLEEP_LEVEL_1);
    rd(`OFS_STATE_WORD, 32'h0000_0058);
    // every reset class event fetches the top slot
    for (int e = 0; e < 3; e++) begin
      ext_reset_i <= (e == 0);
      wdt_reset_i <= (e == 1);
      flash_key_fault_i <= (e == 2);
      tick(1);
      {ext_reset_i, wdt_reset_i, flash_key_fault_i} <= 3'b000;
      serve(4'hf);
      tick(3);
    end
    test_done();
  end
endmodule
